// ### logic/dtpc_out_map.sv
// Output terminal mapper: function code to flag with polarity
`timescale 1ns/1ps
module dtpc_out_map (
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RESETN_IN,
    // Selection and flags
    input wire logic [7:0] FUNC_CODE_IN,
    input wire dtpc_pkg::dtpc_flags_t FLAGS_IN,
    // Terminal drive
    output logic TERM_OUT
);
    import dtpc_pkg::*;

    wire logic inv = FUNC_CODE_IN >= DTPC_OUT_INV;
    wire logic [7:0] base = inv ? FUNC_CODE_IN - DTPC_OUT_INV
                                : FUNC_CODE_IN;
    wire logic sel_flag = (base == DTPC_OUT_FN_UPPER) ? FLAGS_IN.upper :
                          (base == DTPC_OUT_FN_LOWER) ? FLAGS_IN.lower :
                          (base == DTPC_OUT_FN_DIR) ? FLAGS_IN.dir :
                          (base == DTPC_OUT_FN_LOOP) ? FLAGS_IN.loop :
                          1'b0;
    wire logic nxt_term = sel_flag ^ inv;

    // Registered so the open-collector drive never glitches
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            TERM_OUT <= 1'b0;
        end else begin
            TERM_OUT <= nxt_term;
        end
    end

    // Code 147 must show the loop flag inverted one cycle later
    chk_out_polarity: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RESETN_IN)
        (FUNC_CODE_IN == DTPC_OUT_INV + DTPC_OUT_FN_LOOP) |=>
        (TERM_OUT == !$past(FLAGS_IN.loop)))
        else $error("inverted loop terminal wrong");
endmodule

// ### logic/dtpc_pkg.sv
// Package: constants and types for the dancer tension loop controller
// Functional notes
// - Action codes 40 to 43 select dancer mode
// - Loop result added to main speed command
// - Main speed ramps on second accel/decel times
// - Input function code 14 routes dancer enable
// - No enable terminal: action code alone decides
// - Code zero or enable off: normal operation
// - Network enable bit acts like the terminal
// - Position scaled 0-100% per scaling select
// - Upper flag when reading exceeds set limit
// - Lower flag when reading below set limit
// - Direction flag on only for forward rotation
// - Loop-active flag on during dancer control
// - Output codes 100 and up invert logic
// - Target from setting, measured from analog
// - Setting 9999 means fixed fifty percent target
// - 40/42 reverse, 41/43 forward; 42/43 ratio
// - Loop flag off normally, on at loop stop; code only holds an already-set loop flag during loop stop
package dtpc_pkg;
    // ------------------------------------------------------------
    // Codes and settings
    // ------------------------------------------------------------
    localparam logic [7:0] DTPC_ACT_FIRST = 8'h28;   // 40
    localparam logic [7:0] DTPC_ACT_REV_FIX = 8'h28; // 40
    localparam logic [7:0] DTPC_ACT_FWD_FIX = 8'h29; // 41
    localparam logic [7:0] DTPC_ACT_REV_RAT = 8'h2a; // 42
    localparam logic [7:0] DTPC_ACT_LAST = 8'h2b;    // 43
    localparam logic [7:0] DTPC_IN_FN_ENABLE = 8'h0e; // 14
    localparam logic [7:0] DTPC_OUT_FN_LOWER = 8'h0e; // 14
    localparam logic [7:0] DTPC_OUT_FN_UPPER = 8'h0f; // 15
    localparam logic [7:0] DTPC_OUT_FN_DIR = 8'h10;   // 16
    localparam logic [7:0] DTPC_OUT_FN_LOOP = 8'h2f;  // 47
    localparam logic [7:0] DTPC_OUT_INV = 8'h64;      // 100
    localparam logic [13:0] DTPC_NO_FUNC = 14'h270f;  // 9999
    // Positions are tenths of a percent, 0..1000
    localparam logic [13:0] DTPC_POS_FULL = 14'h03e8;
    localparam logic [13:0] DTPC_POS_HALF = 14'h01f4;
    // Raw analog code scale (12-bit converter, full range)
    localparam logic [11:0] DTPC_ADC_4MA = 12'h333;  // 4/20 of full
    localparam logic [11:0] DTPC_ADC_5V = 12'h7ff;   // half of 10 V range
    localparam logic [11:0] DTPC_ADC_FULL = 12'hfff;
    localparam logic [1:0] DTPC_SCL_CUR = 2'h0;
    localparam logic [1:0] DTPC_SCL_5V = 2'h1;
    localparam logic [1:0] DTPC_SCL_10V = 2'h2;
    localparam int DTPC_N_IN_TERM = 7;
    localparam int DTPC_N_OUT_TERM = 3;

    // Sample period: 1 ms at 40 MHz
    localparam int DTPC_SAMPLE_US = 1000;
    localparam int DTPC_CLK_MHZ = 40;
    localparam int DTPC_SAMPLE_CYC = DTPC_SAMPLE_US * DTPC_CLK_MHZ;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {DTPC_RUN_STOP, DTPC_RUN_FWD, DTPC_RUN_REV}
        dtpc_dir_t;

    typedef struct packed {
        logic [7:0] action;       // loop_action_select
        logic [13:0] target;      // target_position_setting
        logic [13:0] upper;       // upper_limit_setting
        logic [13:0] lower;       // lower_limit_setting
        logic [1:0] scaling;      // input_scaling_select
    } dtpc_cfg_t;

    typedef struct packed {
        logic upper;
        logic lower;
        logic dir;
        logic loop;
    } dtpc_flags_t;
endpackage

// ### logic/dtpc_top.sv
// Dancer tension loop controller: mode, scaling, flags, speed sum
`timescale 1ns/1ps
module dtpc_top #(
    parameter int SAMPLE_CYC = dtpc_pkg::DTPC_SAMPLE_CYC,
    parameter int SPD_W = 16
) (
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RESETN_IN,
    // Configuration settings
    input wire dtpc_pkg::dtpc_cfg_t CFG_IN,
    input wire logic [dtpc_pkg::DTPC_N_IN_TERM*8-1:0] IN_FUNC_SEL_IN,
    input wire logic [dtpc_pkg::DTPC_N_OUT_TERM*8-1:0] OUT_FUNC_SEL_IN,
    // Input terminals (pins) and network terminal bits
    input wire logic [dtpc_pkg::DTPC_N_IN_TERM-1:0] IN_TERM_IN,
    input wire logic [dtpc_pkg::DTPC_N_IN_TERM-1:0] NET_TERM_IN,
    input wire logic NET_MODE_IN,
    // Analog position sample from the converter
    input wire logic [11:0] POS_ADC_IN,
    // Speed path
    input wire logic [SPD_W-1:0] MAIN_SPEED_IN,
    input wire logic signed [SPD_W-1:0] LOOP_RESULT_IN,
    input wire logic [SPD_W-1:0] SPEED_RATIO_IN,
    input wire dtpc_pkg::dtpc_dir_t ROTATION_IN,
    input wire logic LOOP_STOP_IN,
    // Loop interface outputs
    output logic [13:0] TARGET_POS_OUT,
    output logic [13:0] MEASURED_POS_OUT,
    output logic LOOP_REVERSE_OUT,
    output logic RATIO_MODE_OUT,
    output logic USE_SECOND_RAMP_OUT,
    output logic [SPD_W-1:0] SPEED_CMD_OUT,
    // Flags and mapped output terminals
    output dtpc_pkg::dtpc_flags_t FLAGS_OUT,
    output logic [dtpc_pkg::DTPC_N_OUT_TERM-1:0] OUT_TERM_OUT
);
    import dtpc_pkg::*;

    // Refuse sizes the counter and the speed sum cannot serve
    if (SAMPLE_CYC < 2 || SPD_W < 8 || SPD_W > 30) begin : g_bad_param
        $error("dtpc_top: unsupported parameter value");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [DTPC_N_IN_TERM-1:0] term_meta_ff;
    logic [DTPC_N_IN_TERM-1:0] term_sync_ff;
    // Terminal pins are asynchronous to the core clock
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            term_meta_ff <= '0;
            term_sync_ff <= '0;
        end else begin
            term_meta_ff <= IN_TERM_IN;
            term_sync_ff <= term_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // Enable routing and mode decode
    // ------------------------------------------------------------
    logic [DTPC_N_IN_TERM-1:0] en_assigned;
    logic [DTPC_N_IN_TERM-1:0] en_active;
    // Network bits stand in for the pins when the network drives them
    wire logic [DTPC_N_IN_TERM-1:0] term_level =
        NET_MODE_IN ? NET_TERM_IN : term_sync_ff;
    for (genvar i = 0; i < DTPC_N_IN_TERM; i++) begin : g_en
        assign en_assigned[i] =
            IN_FUNC_SEL_IN[i*8 +: 8] == DTPC_IN_FN_ENABLE;
        assign en_active[i] = en_assigned[i] & term_level[i];
    end
    wire logic any_assigned = |en_assigned;
    wire logic dancer_enable_input = |en_active;
    wire logic act_in_range = CFG_IN.action >= DTPC_ACT_FIRST &&
                              CFG_IN.action <= DTPC_ACT_LAST;
    // Unassigned enable leaves the action code alone in charge
    wire logic dancer_mode = act_in_range &&
        (!any_assigned || dancer_enable_input);
    wire logic act_reverse = CFG_IN.action == DTPC_ACT_REV_FIX ||
                             CFG_IN.action == DTPC_ACT_REV_RAT;
    // Codes above 43 are not ratio codes, so gate by the range
    wire logic act_ratio = act_in_range &&
                           CFG_IN.action > DTPC_ACT_FWD_FIX;

    // ------------------------------------------------------------
    // Position scaling to tenths of a percent
    // ------------------------------------------------------------
    logic [11:0] span;
    logic [11:0] offs;
    // Below-range current reads clip to zero rather than wrap
    always_comb begin
        unique case (CFG_IN.scaling)
            DTPC_SCL_5V: begin
                span = DTPC_ADC_5V;
                offs = 12'h000;
            end
            DTPC_SCL_10V: begin
                span = DTPC_ADC_FULL;
                offs = 12'h000;
            end
            default: begin
                span = DTPC_ADC_FULL - DTPC_ADC_4MA;
                offs = DTPC_ADC_4MA;
            end
        endcase
    end
    wire logic [11:0] above = (POS_ADC_IN > offs) ? POS_ADC_IN - offs
                                                  : 12'h000;
    wire logic [11:0] clip = (above > span) ? span : above;
    wire logic [23:0] prod = clip * DTPC_POS_FULL[9:0];
    wire logic [13:0] scaled = 14'(prod / span);
    wire logic [13:0] target = (CFG_IN.target == DTPC_NO_FUNC) ?
        DTPC_POS_HALF : CFG_IN.target;

    // ------------------------------------------------------------
    // Sample timer and flag evaluation
    // ------------------------------------------------------------
    localparam int CW = $clog2(SAMPLE_CYC);
    logic [CW-1:0] samp_cnt_ff;
    wire logic samp_tick = samp_cnt_ff == CW'(SAMPLE_CYC - 1);
    wire logic [CW-1:0] nxt_samp_cnt = samp_tick ? '0 : samp_cnt_ff + 1'b1;
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            samp_cnt_ff <= '0;
        end else begin
            samp_cnt_ff <= nxt_samp_cnt;
        end
    end

    wire logic nxt_upper = act_in_range && CFG_IN.upper != DTPC_NO_FUNC &&
        scaled > CFG_IN.upper;
    wire logic nxt_lower = act_in_range && CFG_IN.lower != DTPC_NO_FUNC &&
        scaled < CFG_IN.lower;
    wire logic nxt_dir = ROTATION_IN == DTPC_RUN_FWD;
    wire logic nxt_loop = dancer_mode; // (held through loop stops)
    dtpc_flags_t flags_ff;
    logic [13:0] meas_ff;
    // Limit flags refresh once per sample, others track every cycle
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            flags_ff <= '0;
            meas_ff <= '0;
        end else begin
            if (samp_tick) begin
                flags_ff.upper <= nxt_upper;
                flags_ff.lower <= nxt_lower;
                meas_ff <= scaled;
            end
            flags_ff.dir <= nxt_dir;
            flags_ff.loop <= nxt_loop || (flags_ff.loop && LOOP_STOP_IN);
        end
    end

    // ------------------------------------------------------------
    // Speed command sum
    // ------------------------------------------------------------
    localparam int PW = 2 * SPD_W;
    wire logic signed [PW-1:0] ratio_prod = PW'(signed'(LOOP_RESULT_IN)) *
        signed'(PW'(SPEED_RATIO_IN));
    wire logic signed [SPD_W+1:0] corr = act_ratio ?
        (SPD_W+2)'(ratio_prod >>> SPD_W) :
        (SPD_W+2)'(LOOP_RESULT_IN);
    wire logic signed [SPD_W+1:0] sum = signed'((SPD_W+2)'(MAIN_SPEED_IN)) +
        (flags_ff.loop ? corr : '0);
    wire logic [SPD_W-1:0] nxt_speed = sum[SPD_W+1] ? '0 :
        (sum[SPD_W] ? '1 : sum[SPD_W-1:0]);
    // Registered outputs
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            SPEED_CMD_OUT <= '0;
            TARGET_POS_OUT <= DTPC_POS_HALF;
            LOOP_REVERSE_OUT <= 1'b0;
            RATIO_MODE_OUT <= 1'b0;
            USE_SECOND_RAMP_OUT <= 1'b0;
        end else begin
            SPEED_CMD_OUT <= nxt_speed;
            TARGET_POS_OUT <= target;
            LOOP_REVERSE_OUT <= act_reverse;
            RATIO_MODE_OUT <= act_ratio;
            USE_SECOND_RAMP_OUT <= dancer_mode;
        end
    end
    assign MEASURED_POS_OUT = meas_ff;
    assign FLAGS_OUT = flags_ff;

    // ------------------------------------------------------------
    // Output terminal mapping
    // ------------------------------------------------------------
    for (genvar j = 0; j < DTPC_N_OUT_TERM; j++) begin : g_out
        dtpc_out_map u_map (
            .CORE_CLK_IN(CORE_CLK_IN),
            .RESETN_IN(RESETN_IN),
            .FUNC_CODE_IN(OUT_FUNC_SEL_IN[j*8 +: 8]),
            .FLAGS_IN(flags_ff),
            .TERM_OUT(OUT_TERM_OUT[j])
        );
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_mode_range: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RESETN_IN)
        !act_in_range |=> !USE_SECOND_RAMP_OUT)
        else $error("dancer ramp outside action range");
    chk_unassigned_mode: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RESETN_IN)
        (act_in_range && !any_assigned) |=> USE_SECOND_RAMP_OUT)
        else $error("unassigned enable did not allow mode");
    chk_enable_off: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RESETN_IN)
        (any_assigned && !dancer_enable_input) |=> !USE_SECOND_RAMP_OUT)
        else $error("mode ran with enable off");
    chk_loop_flag: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RESETN_IN)
        dancer_mode |=> FLAGS_OUT.loop)
        else $error("loop flag missing");
    chk_normal_speed: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RESETN_IN)
        (!flags_ff.loop && !MAIN_SPEED_IN[SPD_W-1]) |=>
        SPEED_CMD_OUT == $past(MAIN_SPEED_IN))
        else $error("speed altered outside dancer mode");
    chk_upper_hold: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RESETN_IN)
        !samp_tick |=> $stable(FLAGS_OUT.upper))
        else $error("upper flag moved between samples");
    chk_upper_off: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RESETN_IN)
        (samp_tick && CFG_IN.upper == DTPC_NO_FUNC) |=> !FLAGS_OUT.upper)
        else $error("upper flag with limit disabled");
    chk_lower_set: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RESETN_IN)
        (samp_tick && act_in_range && CFG_IN.lower != DTPC_NO_FUNC &&
        scaled < CFG_IN.lower) |=> FLAGS_OUT.lower)
        else $error("lower flag missing");
    chk_dir_flag: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RESETN_IN)
        ROTATION_IN != DTPC_RUN_FWD |=> !FLAGS_OUT.dir)
        else $error("direction flag on while not forward");
    chk_half_target: assert property (@(posedge CORE_CLK_IN)
        disable iff (!RESETN_IN)
        CFG_IN.target == DTPC_NO_FUNC |=> TARGET_POS_OUT == DTPC_POS_HALF)
        else $error("default target not fifty percent");
    cov_dancer: cover property (@(posedge CORE_CLK_IN) dancer_mode);
    cov_upper: cover property (@(posedge CORE_CLK_IN) FLAGS_OUT.upper);
    cov_ratio: cover property (@(posedge CORE_CLK_IN)
        dancer_mode && act_ratio);
    cov_loop_stop: cover property (@(posedge CORE_CLK_IN)
        !dancer_mode && FLAGS_OUT.loop);
endmodule

// ### tb/dtpc_field_model.sv
// Field-side model: dancer position sensor and input terminal pins
`timescale 1ns/1ps
module dtpc_field_model (
    // Clock
    input wire logic clk_in,
    // Position and pin levels requested by the bench
    input wire logic [1:0] scaling_in,
    input wire logic [13:0] pos_in,
    input wire logic [6:0] pins_in,
    // Drive into the device
    output logic [11:0] adc_out,
    output logic [6:0] pins_out
);
    import dtpc_pkg::*;
    logic [23:0] span;
    logic [11:0] base;
    logic [11:0] code;
    // Converter code for a position in tenths of a percent
    assign span = (scaling_in == DTPC_SCL_CUR) ?
        24'(DTPC_ADC_FULL - DTPC_ADC_4MA) :
        (scaling_in == DTPC_SCL_5V) ? 24'(DTPC_ADC_5V) : 24'(DTPC_ADC_FULL);
    assign base = (scaling_in == DTPC_SCL_CUR) ? DTPC_ADC_4MA : 12'h000;
    assign code = 12'((24'(pos_in) * span) / 24'h3e8) + base;
    // Wiring settles a little after each edge, never on it
    initial begin
        adc_out = 12'h000;
        pins_out = 7'h00;
    end
    always @(posedge clk_in) begin
        adc_out <= #3 code;
        pins_out <= #3 pins_in;
    end
endmodule

// ### tb/dtpc_top_test.sv
// Self-checking bench for the dancer tension loop controller
`timescale 1ns/1ps
module dtpc_top_test;
    import dtpc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int SAMPLE = 8;
    localparam int SETTLE = 2 * SAMPLE + 6; // Covers sync, sample, mapping
    localparam int LIMIT = 4000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    dtpc_cfg_t cfg;
    logic [55:0] in_sel = 56'h0;
    logic [23:0] out_sel = 24'h0;
    logic [6:0] pins = 7'h00;
    logic [6:0] pin_lvl;
    logic [6:0] net_bits = 7'h00;
    logic net_mode = 1'b0;
    logic [13:0] pos = 14'h0;
    logic [11:0] adc;
    logic [15:0] main_spd = 16'h0;
    logic signed [15:0] loop_res = 16'sh0;
    logic [15:0] ratio = 16'h0;
    dtpc_dir_t rot = DTPC_RUN_STOP;
    logic loop_stop = 1'b0;
    logic [13:0] target_pos;
    logic [13:0] meas_pos;
    logic loop_rev;
    logic ratio_mode;
    logic second_ramp;
    logic [15:0] speed_cmd;
    dtpc_flags_t flags;
    logic [2:0] terms;
    logic on;
    logic [7:0] acts [7] = '{8'h00, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c};
    int failures = 0;
    int tests_run = 0;
    int cycles = 0;
    // ------------------------------------------------------------
    // Device and field model
    // ------------------------------------------------------------
    dtpc_top #(.SAMPLE_CYC(SAMPLE), .SPD_W(16)) i_dtpc_top (
        .CORE_CLK_IN(clk), .RESETN_IN(rst_n), .CFG_IN(cfg),
        .IN_FUNC_SEL_IN(in_sel), .OUT_FUNC_SEL_IN(out_sel),
        .IN_TERM_IN(pin_lvl), .NET_TERM_IN(net_bits), .NET_MODE_IN(net_mode),
        .POS_ADC_IN(adc), .MAIN_SPEED_IN(main_spd), .LOOP_RESULT_IN(loop_res),
        .SPEED_RATIO_IN(ratio), .ROTATION_IN(rot), .LOOP_STOP_IN(loop_stop),
        .TARGET_POS_OUT(target_pos), .MEASURED_POS_OUT(meas_pos),
        .LOOP_REVERSE_OUT(loop_rev), .RATIO_MODE_OUT(ratio_mode),
        .USE_SECOND_RAMP_OUT(second_ramp), .SPEED_CMD_OUT(speed_cmd),
        .FLAGS_OUT(flags), .OUT_TERM_OUT(terms));
    dtpc_field_model i_dtpc_field_model (
        .clk_in(clk), .scaling_in(cfg.scaling), .pos_in(pos),
        .pins_in(pins), .adc_out(adc), .pins_out(pin_lvl));
    // ------------------------------------------------------------
    // Clock, watchdog and helpers
    // ------------------------------------------------------------
    initial begin
        forever #12.5 clk = ~clk;
    end
    // A hang counts as a mismatch rather than running forever
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic check_bit(input string what, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic check_vec(input string what, input logic [15:0] e,
                             input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // Applies one speed case and compares the summed command
    task automatic speed_case(input logic [7:0] act, input logic [15:0] m,
                              input logic [15:0] l, input logic [15:0] r,
                              input logic [15:0] e);
        cfg.action = act;
        main_spd = m;
        loop_res = l;
        ratio = r;
        settle(SETTLE);
        check_vec("speed_cmd", e, speed_cmd);
    endtask
    task automatic limit_case(input logic [13:0] p, input logic u,
                              input logic l);
        pos = p;
        settle(SETTLE);
        check_bit("upper_flag", u, flags.upper);
        check_bit("lower_flag", l, flags.lower);
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        cfg = '{8'h00, DTPC_NO_FUNC, DTPC_NO_FUNC, DTPC_NO_FUNC, DTPC_SCL_CUR};
        settle(16);
        rst_n = 1'b1;
        settle(SETTLE);
        check_vec("target", 16'h01f4, 16'(target_pos));
        cfg.target = 14'h012c;
        settle(SETTLE);
        check_vec("target", 16'h012c, 16'(target_pos));
        $display("Test target done");
        // Codes just outside 40..43 must leave normal operation
        foreach (acts[i]) begin
            cfg.action = acts[i];
            settle(SETTLE);
            on = (acts[i] >= DTPC_ACT_FIRST) && (acts[i] <= DTPC_ACT_LAST);
            check_bit("second_ramp", on, second_ramp);
            check_bit("loop_flag", on, flags.loop);
            check_bit("loop_rev", on & ~acts[i][0], loop_rev);
            check_bit("ratio_mode", on & acts[i][1], ratio_mode);
        end
        $display("Test modes done");
        in_sel[31:24] = DTPC_IN_FN_ENABLE;
        cfg.action = 8'h29;
        settle(SETTLE);
        check_bit("enable_off", 1'b0, second_ramp);
        pins[3] = 1'b1;
        settle(SETTLE);
        check_bit("enable_pin", 1'b1, second_ramp);
        pins[3] = 1'b0;
        net_mode = 1'b1;
        net_bits[3] = 1'b1;
        settle(SETTLE);
        check_bit("enable_net", 1'b1, flags.loop);
        net_bits[3] = 1'b0;
        settle(SETTLE);
        check_bit("enable_net", 1'b0, flags.loop);
        net_mode = 1'b0;
        in_sel = 56'h0;
        $display("Test enable done");
        // Main speed steps land at once: the device applies no ramp of its own
        speed_case(8'h29, 16'h03e8, 16'h00c8, 16'h0, 16'h04b0);
        speed_case(8'h29, 16'hfff0, 16'h0100, 16'h0, 16'hffff);
        speed_case(8'h28, 16'h000a, 16'hff9c, 16'h0, 16'h0000);
        speed_case(8'h2b, 16'h03e8, 16'h00c8, 16'h8000, 16'h044c);
        speed_case(8'h00, 16'h03e8, 16'h00c8, 16'h0, 16'h03e8);
        $display("Test speed done");
        for (int s = 0; s < 3; s++) begin
            cfg.scaling = 2'(s);
            pos = 14'h0;
            settle(SETTLE);
            check_vec("meas_zero", 16'h0, 16'(meas_pos));
            pos = DTPC_POS_FULL;
            settle(SETTLE);
            check_vec("meas_full", 16'h03e8, 16'(meas_pos));
        end
        $display("Test scaling done");
        cfg.action = 8'h29;
        cfg.upper = 14'h0258;
        cfg.lower = 14'h0190;
        limit_case(DTPC_POS_FULL, 1'b1, 1'b0);
        limit_case(14'h0, 1'b0, 1'b1);
        limit_case(DTPC_POS_HALF, 1'b0, 1'b0);
        cfg.lower = DTPC_NO_FUNC;
        limit_case(14'h0, 1'b0, 1'b0);
        cfg.upper = DTPC_NO_FUNC;
        limit_case(DTPC_POS_FULL, 1'b0, 1'b0);
        cfg.upper = 14'h0258;
        cfg.action = 8'h00;
        limit_case(DTPC_POS_FULL, 1'b0, 1'b0);
        $display("Test limits done");
        cfg.action = 8'h29;
        cfg.lower = 14'h0190;
        for (int d = 0; d < 3; d++) begin
            rot = dtpc_dir_t'(d);
            settle(SETTLE);
            check_bit("dir_flag", d == 1, flags.dir);
        end
        rot = DTPC_RUN_FWD;
        out_sel = 24'h2f7410; // Codes 47, 116, 16
        settle(SETTLE);
        check_vec("terms", 16'h0005, 16'(terms));
        out_sel = 24'h93720f; // Codes 147, 114, 15
        settle(SETTLE);
        check_vec("terms", 16'h0003, 16'(terms));
        out_sel = 24'h730e93; // Codes 115, 14, 147
        limit_case(14'h0, 1'b0, 1'b1);
        check_vec("terms", 16'h0006, 16'(terms));
        $display("Test terminals done");
        loop_stop = 1'b1;
        cfg.action = 8'h00;
        settle(SETTLE);
        check_bit("loop_hold", 1'b1, flags.loop);
        loop_stop = 1'b0;
        settle(SETTLE);
        check_bit("loop_off", 1'b0, flags.loop);
        $display("Test loop stop done");
        report_and_stop();
    end
endmodule
